// ---- include/bbs_pkg.sv ----
`default_nettype none
package bbs_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 23;
  localparam int LANE_W = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 40;
  localparam int BERR_TIME_NS = 10000;
  localparam int BERR_CYC     = BERR_TIME_NS * CLK_MHZ / 1000;
  localparam int IMA_HIGH_NS  = 50;
  localparam int IMA_HIGH_CYC = (IMA_HIGH_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Address decode reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] DEC_BASE_RST = 23'h300000;
  localparam logic [ADDR_W-1:0] DEC_MASK_RST = 23'h7f0000;

  // ----------------------------------------------------------------
  // Control synchroniser bit positions and reset value
  // ----------------------------------------------------------------
  localparam int SY_SHORT = 0;
  localparam int SY_LONG  = 1;
  localparam int SY_LDS   = 2;
  localparam int SY_UDS   = 3;
  localparam int SY_IACK  = 4;
  localparam int SY_ACKA  = 5;
  localparam int SY_RD    = 6;
  localparam int SY_LWD   = 7;
  localparam int SY_TEST  = 8;
  localparam int SY_CTL_W = 9;
  localparam logic [SY_CTL_W-1:0] SY_CTL_RST = 9'h1ff;

  // ----------------------------------------------------------------
  // Cycle states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_ACK  = 2'b11,
    ST_REL  = 2'b10
  } bbs_state_e;
endpackage
`default_nettype wire

// ---- rtl/bbs_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module bbs_sync #(
  parameter int           W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  // ----------------------------------------------------------------
  // Two flops per bit
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_ff <= RST[gi];
          sync_ff <= RST[gi];
        end else begin
          meta_ff <= din[gi];
          sync_ff <= meta_ff;
        end
      end
      assign dout[gi] = sync_ff;
    end
  endgenerate
endmodule
`default_nettype wire

// ---- rtl/bbs_berr_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module bbs_berr_timer
  import bbs_pkg::*;
#(
  parameter int LIMIT = BERR_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Cycle status
  input  wire logic cyc_active,
  input  wire logic ack_all_n,
  input  wire logic enable,
  // Result
  output logic      timeout_ff
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);

  logic [CW-1:0] cnt_ff;
  logic          run;

  assign run = enable && cyc_active && ack_all_n;

  // ----------------------------------------------------------------
  // Cycle length counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
    end else if (!run) begin
      cnt_ff <= '0;
    end else if (cnt_ff != LIM) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Timeout flag
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      timeout_ff <= 1'b0;
    end else begin
      timeout_ff <= run && (cnt_ff == LIM);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/bbs_front_end.sv ----
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1 - Address input holds bits 23..1; byte choice comes from data strobes.
// RULE2 - Primary 16-bit lanes carry byte and word data.
// RULE3 - Extension lanes used only for long words, undriven otherwise.
// RULE4 - Master asserts short strobe only with a valid 24-bit address.
// RULE5 - Long strobe marks 32-bit address; both strobes when upper byte zero.
// RULE6 - Lower strobe marks write data bits 7..0, permits read drive.
// RULE7 - Upper strobe marks write data bits 15..8, permits read drive.
// RULE8 - Direction input high means read, low means write.
// RULE9 - Outside logic asserts ack-all whenever any bus acknowledge asserts.
// RULE10 - Ack-all low suppresses the bus-error timeout.
// RULE11 - In test mode ack-all serves as scan enable.
// RULE12 - Scan enable high shifts the chain, low captures in parallel.
// RULE13 - Interrupt acknowledge reaches only the bus-error timer.
// RULE14 - Timer starts and stops on OR of iack and both address strobes.
// RULE15 - Master never asserts address strobes during interrupt acknowledge.
// RULE16 - Word acknowledge is open drain, pulled low only.
// RULE17 - Bus error pulled low when a cycle outlasts the allowed time.
// RULE18 - Addressed indication low when a valid enabled address decodes.
// RULE19 - Long word acknowledge is open drain, pulled low only.
// RULE20 - All strobes pass a two-flop synchroniser before use.
// RULE21 - Data lanes driven only on decoded reads, only strobed lanes.
module bbs_front_end
  import bbs_pkg::*;
#(
  parameter int                BERR_LIMIT = BERR_CYC,
  parameter logic [ADDR_W-1:0] DEC_BASE   = DEC_BASE_RST,
  parameter logic [ADDR_W-1:0] DEC_MASK   = DEC_MASK_RST
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // Bus address and strobes
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic              short_addr_strobe_n,
  input  wire logic              long_addr_strobe_n,
  input  wire logic              lower_data_strobe_n,
  input  wire logic              upper_data_strobe_n,
  input  wire logic              read_not_write,
  input  wire logic              long_word_n,
  input  wire logic              int_ack_n,
  input  wire logic              ack_all_n,
  input  wire logic              test_mode_n,
  // Primary data lanes
  input  wire logic [LANE_W-1:0] primary_data_lanes_i,
  output logic      [LANE_W-1:0] primary_data_lanes_o,
  output logic      [LANE_W-1:0] primary_data_lanes_oe,
  // Extension data lanes
  input  wire logic [LANE_W-1:0] ext_data_lanes_i,
  output logic      [LANE_W-1:0] ext_data_lanes_o,
  output logic      [LANE_W-1:0] ext_data_lanes_oe,
  // Open-drain answers and tri-state addressed indication
  output logic                   half_ack_n_o,
  output logic                   half_ack_n_oe,
  output logic                   full_size_ack_n_o,
  output logic                   full_size_ack_n_oe,
  output logic                   bus_err_n_o,
  output logic                   bus_err_n_oe,
  input  wire logic              addressed_n_i,
  output logic                   addressed_n_o,
  output logic                   addressed_n_oe,
  // Scan control
  output logic                   scan_mode,
  output logic                   scan_shift_en,
  // Function side
  input  wire logic              func_enable,
  output logic                   usr_req,
  output logic                   usr_wr,
  output logic                   usr_long,
  output logic      [ADDR_W-1:0] usr_addr,
  output logic      [3:0]        usr_be,
  output logic      [31:0]       usr_wdata,
  input  wire logic              usr_ack,
  input  wire logic [31:0]       usr_rdata
);
  localparam int SY_W = SY_CTL_W + ADDR_W + 2 * LANE_W;
  localparam logic [SY_W-1:0] SY_RST = {{(ADDR_W + 2 * LANE_W){1'b0}}, SY_CTL_RST};
  localparam int RCW = $clog2(IMA_HIGH_CYC + 1);
  localparam logic [RCW-1:0] REL_LAST = RCW'(IMA_HIGH_CYC - 1);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [SY_W-1:0]     sy_out;
  logic [SY_CTL_W-1:0] ctl_s;
  logic [ADDR_W-1:0]   addr_s;
  logic [LANE_W-1:0]   pri_s;
  logic [LANE_W-1:0]   ext_s;

  bbs_sync #(
    .W   (SY_W),
    .RST (SY_RST)
  ) u_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .din     ({ext_data_lanes_i, primary_data_lanes_i, bus_addr,
                test_mode_n, long_word_n, read_not_write, ack_all_n,
                int_ack_n, upper_data_strobe_n, lower_data_strobe_n,
                long_addr_strobe_n, short_addr_strobe_n}),
    .dout    (sy_out)
  ); // RULE20

  assign ctl_s  = sy_out[SY_CTL_W-1:0];
  assign addr_s = sy_out[SY_CTL_W +: ADDR_W]; // RULE1
  assign pri_s  = sy_out[SY_CTL_W + ADDR_W +: LANE_W];
  assign ext_s  = sy_out[SY_CTL_W + ADDR_W + LANE_W +: LANE_W];

  logic short_as;
  logic long_as;
  logic lds_as;
  logic uds_as;
  logic iack_as;
  logic acka_s;
  logic rd_s;
  logic lwd_as;
  logic test_as;
  logic as_any;
  logic ds_any;
  logic hit;

  assign short_as = !ctl_s[SY_SHORT];
  assign long_as  = !ctl_s[SY_LONG];
  assign lds_as   = !ctl_s[SY_LDS];
  assign uds_as   = !ctl_s[SY_UDS];
  assign iack_as  = !ctl_s[SY_IACK];
  assign acka_s   = ctl_s[SY_ACKA];
  assign rd_s     = ctl_s[SY_RD]; // RULE8
  assign lwd_as   = !ctl_s[SY_LWD];
  assign test_as  = !ctl_s[SY_TEST];
  assign as_any   = short_as || long_as;
  assign ds_any   = lds_as || uds_as;
  assign hit      = short_as && func_enable && ((addr_s & DEC_MASK) == DEC_BASE); // RULE18

  // ----------------------------------------------------------------
  // Bus-error timer
  // ----------------------------------------------------------------
  logic timeout;

  bbs_berr_timer #(
    .LIMIT (BERR_LIMIT)
  ) u_timer (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .cyc_active (iack_as || long_as || short_as), // RULE14 RULE13
    .ack_all_n  (acka_s), // RULE10
    .enable     (!test_as),
    .timeout_ff (timeout)
  );

  // ----------------------------------------------------------------
  // Cycle state machine
  // ----------------------------------------------------------------
  bbs_state_e      state_ff;
  logic            rd_ff;
  logic            lw_ff;
  logic [RCW-1:0]  rel_cnt_ff;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (hit && ds_any && !test_as) begin
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!as_any) begin
            state_ff <= ST_REL;
          end else if (usr_ack) begin
            state_ff <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (!as_any) begin
            state_ff <= ST_REL;
          end
        end
        ST_REL: begin
          if (rel_cnt_ff == REL_LAST) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rel_cnt_ff <= '0;
    end else if (state_ff == ST_REL) begin
      rel_cnt_ff <= rel_cnt_ff + 1'b1;
    end else begin
      rel_cnt_ff <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_ff     <= 1'b1;
      lw_ff     <= 1'b0;
      usr_req   <= 1'b0;
      usr_wr    <= 1'b0;
      usr_long  <= 1'b0;
      usr_addr  <= '0;
      usr_be    <= 4'h0;
      usr_wdata <= 32'h0;
    end else begin
      usr_req <= 1'b0;
      if (state_ff == ST_IDLE && hit && ds_any && !test_as) begin
        rd_ff     <= rd_s;
        lw_ff     <= lwd_as;
        usr_req   <= 1'b1;
        usr_wr    <= !rd_s; // RULE8
        usr_long  <= lwd_as;
        usr_addr  <= addr_s; // RULE1
        usr_be    <= lwd_as ? 4'hf : {2'b00, uds_as, lds_as}; // RULE6 RULE7
        usr_wdata <= {lwd_as ? ext_s : 16'h0000, pri_s}; // RULE2 RULE3
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data and lane drive
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      primary_data_lanes_o <= 16'h0000;
      ext_data_lanes_o     <= 16'h0000;
    end else if (state_ff == ST_WAIT && usr_ack) begin
      primary_data_lanes_o <= usr_rdata[15:0];
      ext_data_lanes_o     <= usr_rdata[31:16];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      primary_data_lanes_oe <= 16'h0000;
      ext_data_lanes_oe     <= 16'h0000;
    end else if (state_ff == ST_ACK && rd_ff && as_any) begin
      primary_data_lanes_oe <= {{8{uds_as}}, {8{lds_as}}}; // RULE21 RULE6 RULE7
      ext_data_lanes_oe     <= {16{lw_ff && ds_any}}; // RULE3
    end else begin
      primary_data_lanes_oe <= 16'h0000;
      ext_data_lanes_oe     <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Open-drain answers and tri-state addressed indication
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      half_ack_n_o       <= 1'b0;
      half_ack_n_oe      <= 1'b0;
      full_size_ack_n_o  <= 1'b0;
      full_size_ack_n_oe <= 1'b0;
      bus_err_n_o        <= 1'b0;
      bus_err_n_oe       <= 1'b0;
    end else begin
      half_ack_n_oe      <= state_ff == ST_ACK && as_any && !lw_ff; // RULE16
      full_size_ack_n_oe <= state_ff == ST_ACK && as_any && lw_ff; // RULE19
      bus_err_n_oe       <= timeout; // RULE17
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      addressed_n_o  <= 1'b1;
      addressed_n_oe <= 1'b0;
    end else begin
      addressed_n_o  <= state_ff == ST_REL; // RULE18
      addressed_n_oe <= (state_ff == ST_REL) || (state_ff == ST_WAIT)
                        || (state_ff == ST_ACK && as_any);
    end
  end

  // ----------------------------------------------------------------
  // Scan control
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scan_mode     <= 1'b0;
      scan_shift_en <= 1'b0;
    end else begin
      scan_mode     <= test_as; // RULE11
      scan_shift_en <= test_as && acka_s; // RULE11 RULE12
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_addr_capture;
    usr_req |-> usr_addr == $past(addr_s);
  endproperty
  a_addr_capture: assert property (p_addr_capture) else $error("addr capture wrong"); // RULE1

  property p_lane_only_read;
    (|primary_data_lanes_oe) |-> rd_ff && $past(state_ff) == ST_ACK;
  endproperty
  a_lane_only_read: assert property (p_lane_only_read) else $error("lane drive off read"); // RULE21

  property p_ext_only_long;
    (|ext_data_lanes_oe) |-> lw_ff && !(|$past(state_ff ^ ST_ACK));
  endproperty
  a_ext_only_long: assert property (p_ext_only_long) else $error("ext lanes on short"); // RULE3

  property p_low_lane;
    primary_data_lanes_oe[0] |-> $past(lds_as);
  endproperty
  a_low_lane: assert property (p_low_lane) else $error("low lane unstrobed"); // RULE6

  property p_high_lane;
    primary_data_lanes_oe[8] |-> $past(uds_as);
  endproperty
  a_high_lane: assert property (p_high_lane) else $error("high lane unstrobed"); // RULE7

  property p_half_ack;
    state_ff == ST_ACK && as_any && !lw_ff |=> half_ack_n_oe && !half_ack_n_o;
  endproperty
  a_half_ack: assert property (p_half_ack) else $error("word ack missing"); // RULE16

  property p_full_ack;
    full_size_ack_n_oe |-> lw_ff && !half_ack_n_oe && !full_size_ack_n_o;
  endproperty
  a_full_ack: assert property (p_full_ack) else $error("long ack wrong"); // RULE19

  property p_berr;
    timeout |=> bus_err_n_oe && !bus_err_n_o;
  endproperty
  a_berr: assert property (p_berr) else $error("bus error not driven"); // RULE17

  property p_ackall_block;
    !acka_s |-> ##2 !bus_err_n_oe;
  endproperty
  a_ackall_block: assert property (p_ackall_block) else $error("timeout not suppressed"); // RULE10

  property p_scan;
    test_as && acka_s |=> scan_shift_en && scan_mode;
  endproperty
  a_scan: assert property (p_scan) else $error("scan shift missing"); // RULE11

  property p_capture;
    !acka_s || !test_as |=> !scan_shift_en;
  endproperty
  a_capture: assert property (p_capture) else $error("scan shift in capture"); // RULE12

  property p_addressed;
    state_ff == ST_WAIT |=> addressed_n_oe && !addressed_n_o;
  endproperty
  a_addressed: assert property (p_addressed) else $error("addressed not low"); // RULE18

  c_word_read: cover property (half_ack_n_oe && (|primary_data_lanes_oe));
  c_long_write: cover property (full_size_ack_n_oe && !rd_ff);
  c_bus_error: cover property (bus_err_n_oe);
endmodule
`default_nettype wire

// ---- tb/bbs_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bbs_master_model
  import bbs_pkg::*;
(
  // Clock and scan control
  input  wire logic              sys_clk,
  input  wire logic              ack_hold_n,
  // Address and strobes
  output logic      [ADDR_W-1:0] bus_addr,
  output logic                   short_addr_strobe_n,
  output logic                   long_addr_strobe_n,
  output logic                   lower_data_strobe_n,
  output logic                   upper_data_strobe_n,
  output logic                   read_not_write,
  output logic                   long_word_n,
  output logic                   int_ack_n,
  output logic                   ack_all_n,
  // Data lanes
  output logic      [LANE_W-1:0] primary_data_lanes_i,
  input  wire logic [LANE_W-1:0] primary_data_lanes_o,
  input  wire logic [LANE_W-1:0] primary_data_lanes_oe,
  output logic      [LANE_W-1:0] ext_data_lanes_i,
  input  wire logic [LANE_W-1:0] ext_data_lanes_o,
  input  wire logic [LANE_W-1:0] ext_data_lanes_oe,
  // Open-drain answers
  input  wire logic              half_ack_n_oe,
  input  wire logic              full_size_ack_n_oe,
  input  wire logic              bus_err_n_oe
);
  logic        wr_drv = 1'h0;
  logic        tog    = 1'h0;
  logic [31:0] wdat   = '0;
  logic [31:0] mdrv;

  // ----------------------------------------------------------------
  // Lane resolution
  // ----------------------------------------------------------------
  // Released lanes show a moving pattern, never the last value
  always @(posedge sys_clk) tog <= ~tog;
  assign mdrv = wr_drv ? wdat : ({32{tog}} ^ 32'h5a5aa5a5);
  assign primary_data_lanes_i = (primary_data_lanes_oe & primary_data_lanes_o)
                              | (~primary_data_lanes_oe & mdrv[15:0]);
  assign ext_data_lanes_i     = (ext_data_lanes_oe & ext_data_lanes_o)
                              | (~ext_data_lanes_oe & mdrv[31:16]);
  assign ack_all_n = ~half_ack_n_oe & ~full_size_ack_n_oe & ack_hold_n;

  initial begin
    bus_addr            = '0;
    short_addr_strobe_n = 1'h1;
    long_addr_strobe_n  = 1'h1;
    lower_data_strobe_n = 1'h1;
    upper_data_strobe_n = 1'h1;
    read_not_write      = 1'h1;
    long_word_n         = 1'h1;
    int_ack_n           = 1'h1;
  end

  // ----------------------------------------------------------------
  // One bus cycle; sm 0 short, 1 both, 2 long only, 3 int ack
  // ----------------------------------------------------------------
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic rnw, lw,
                      input logic [1:0] sm, ds, input logic [31:0] wd,
                      output logic [31:0] rd, output logic [2:0] seen,
                      output logic [31:0] oe);
    int n;
    @(posedge sys_clk);
    bus_addr       <= a;
    read_not_write <= rnw;
    long_word_n    <= ~lw;
    wdat           <= wd;
    wr_drv         <= ~rnw;
    @(posedge sys_clk);
    short_addr_strobe_n <= ~(sm < 2'h2);
    long_addr_strobe_n  <= ~(sm == 2'h1 || sm == 2'h2);
    int_ack_n           <= ~(sm == 2'h3);
    lower_data_strobe_n <= ~ds[0];
    upper_data_strobe_n <= ~ds[1];
    seen = '0;
    for (n = 0; n < 60 && seen == 3'h0; n++) begin
      @(posedge sys_clk);
      seen = {bus_err_n_oe, full_size_ack_n_oe, half_ack_n_oe};
      rd   = {ext_data_lanes_i, primary_data_lanes_i};
      oe   = {ext_data_lanes_oe, primary_data_lanes_oe};
    end
    short_addr_strobe_n <= 1'h1;
    long_addr_strobe_n  <= 1'h1;
    int_ack_n           <= 1'h1;
    lower_data_strobe_n <= 1'h1;
    upper_data_strobe_n <= 1'h1;
    wr_drv              <= 1'h0;
    for (n = 0; n < 10 && (half_ack_n_oe | full_size_ack_n_oe | bus_err_n_oe); n++)
      @(posedge sys_clk);
    if (half_ack_n_oe | full_size_ack_n_oe | bus_err_n_oe) seen = 3'h7;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ---- tb/bbs_front_end_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module bbs_front_end_tb;
  import bbs_pkg::*;
  localparam int BERR_SIM = 20;
  logic              sys_clk     = 1'h0;
  logic              arst_n      = 1'h0;
  logic              func_enable = 1'h0;
  logic              test_mode_n = 1'h1;
  logic              ack_hold_n  = 1'h1;
  logic              usr_ack     = 1'h0;
  logic [31:0]       usr_rdata   = '0;
  logic [1:0]        ack_dly     = '0;
  logic              addressed_n_i;
  logic [ADDR_W-1:0] bus_addr, usr_addr, cap_addr, a;
  logic              short_addr_strobe_n, long_addr_strobe_n;
  logic              lower_data_strobe_n, upper_data_strobe_n;
  logic              read_not_write, long_word_n, int_ack_n, ack_all_n;
  logic [LANE_W-1:0] primary_data_lanes_i, primary_data_lanes_o, primary_data_lanes_oe;
  logic [LANE_W-1:0] ext_data_lanes_i, ext_data_lanes_o, ext_data_lanes_oe;
  logic              half_ack_n_o, half_ack_n_oe, full_size_ack_n_o, full_size_ack_n_oe;
  logic              bus_err_n_o, bus_err_n_oe, addressed_n_o, addressed_n_oe;
  logic              scan_mode, scan_shift_en, usr_req, usr_wr, usr_long;
  logic              cap_wr, cap_long, rnw, lw;
  logic [3:0]        usr_be, cap_be;
  logic [31:0]       usr_wdata, cap_wd, wd;
  logic [1:0]        ds, sm;
  int                n_req = 0, n_ima = 0, n_hi = 0, n_fail = 0, num_checks = 0, i;

  always #12.5 sys_clk = ~sys_clk;
  assign addressed_n_i = ~addressed_n_oe | addressed_n_o;

  bbs_front_end #(.BERR_LIMIT(BERR_SIM)) i_bbs_front_end (
    .sys_clk, .arst_n, .bus_addr, .short_addr_strobe_n, .long_addr_strobe_n,
    .lower_data_strobe_n, .upper_data_strobe_n, .read_not_write, .long_word_n,
    .int_ack_n, .ack_all_n, .test_mode_n, .primary_data_lanes_i,
    .primary_data_lanes_o, .primary_data_lanes_oe, .ext_data_lanes_i,
    .ext_data_lanes_o, .ext_data_lanes_oe, .half_ack_n_o, .half_ack_n_oe,
    .full_size_ack_n_o, .full_size_ack_n_oe, .bus_err_n_o, .bus_err_n_oe,
    .addressed_n_i, .addressed_n_o, .addressed_n_oe, .scan_mode, .scan_shift_en,
    .func_enable, .usr_req, .usr_wr, .usr_long, .usr_addr, .usr_be, .usr_wdata,
    .usr_ack, .usr_rdata
  );

  bbs_master_model i_bbs_master_model (
    .sys_clk, .ack_hold_n, .bus_addr, .short_addr_strobe_n, .long_addr_strobe_n,
    .lower_data_strobe_n, .upper_data_strobe_n, .read_not_write, .long_word_n,
    .int_ack_n, .ack_all_n, .primary_data_lanes_i, .primary_data_lanes_o,
    .primary_data_lanes_oe, .ext_data_lanes_i, .ext_data_lanes_o,
    .ext_data_lanes_oe, .half_ack_n_oe, .full_size_ack_n_oe, .bus_err_n_oe
  );

  // ----------------------------------------------------------------
  // Function side responder
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    usr_ack <= 1'h0;
    if (usr_req === 1'h1) begin
      n_req    <= n_req + 1;
      cap_addr <= usr_addr;
      cap_wr   <= usr_wr;
      cap_long <= usr_long;
      cap_be   <= usr_be;
      cap_wd   <= usr_wdata;
      ack_dly  <= 2'($urandom_range(3, 1));
    end else if (ack_dly != 2'h0) begin
      ack_dly <= ack_dly - 2'h1;
      if (ack_dly == 2'h1) begin
        usr_ack   <= 1'h1;
        usr_rdata <= $urandom;
      end
    end
    if (addressed_n_oe === 1'h1 && addressed_n_o === 1'h0) n_ima <= n_ima + 1;
    if (addressed_n_oe === 1'h1 && addressed_n_o === 1'h1) n_hi <= n_hi + 1;
  end

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lane_mask(input logic l, input logic [1:0] d);
    return {{16{l}}, {8{d[1]}}, {8{d[0]}}};
  endfunction

  function automatic logic [3:0] exp_be(input logic l, input logic [1:0] d);
    return l ? 4'hf : {2'h0, d};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic run(input logic [ADDR_W-1:0] ad, input logic r, l,
                     input logic [1:0] s, d, input logic [31:0] w,
                     input logic [2:0] eack, input int ereq);
    logic [31:0] rd, oe, m;
    logic [2:0]  seen;
    int          r0, q0, h0;
    r0 = n_req;
    q0 = n_ima;
    h0 = n_hi;
    m  = lane_mask(l, d);
    i_bbs_master_model.xfer(ad, r, l, s, d, w, rd, seen, oe);
    chk(seen, eack);
    chk(n_req - r0, ereq);
    chk(n_ima > q0, ereq);
    chk(n_hi - h0, ereq * IMA_HIGH_CYC);
    chk({half_ack_n_o, full_size_ack_n_o, bus_err_n_o}, '0);
    chk(oe, (ereq != 0 && r) ? m : '0);
    if (ereq != 0) begin
      chk(cap_addr, ad);
      chk({cap_wr, cap_long, cap_be}, {~r, l, exp_be(l, d)});
      if (r) chk(rd & m, usr_rdata & m);
      else chk(cap_wd & {16'hffff, m[15:0]}, w & m);
    end
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h1493));
    repeat (12) @(posedge sys_clk);
    chk({primary_data_lanes_oe, ext_data_lanes_oe}, '0);
    chk({half_ack_n_oe, full_size_ack_n_oe, bus_err_n_oe, addressed_n_oe}, '0);
    arst_n      <= 1'h1;
    func_enable <= 1'h1;
    repeat (2) @(posedge sys_clk);
    for (i = 0; i < 30; i++) begin
      a  = (i < 2) ? (i == 0 ? 23'h300000 : 23'h30ffff) : {7'h30, 16'($urandom)};
      rnw = 1'($urandom);
      lw = (i % 3 == 0);
      ds = lw ? 2'h3 : 2'($urandom_range(3, 1));
      sm = 2'($urandom_range(1, 0));
      wd = $urandom;
      run(a, rnw, lw, sm, ds, wd, lw ? 3'h2 : 3'h1, 1);
    end
    for (i = 0; i < 6; i++) begin
      func_enable <= (i != 1);
      ack_hold_n  <= (i != 5);
      @(posedge sys_clk);
      run(i == 0 ? 23'h310000 : 23'h300010, 1'h1, 1'h0,
          i == 2 ? 2'h2 : (i > 3 ? 2'h3 : 2'h0), i > 2 ? 2'h0 : 2'h3, '0,
          i == 5 ? 3'h0 : 3'h4, 0);
    end
    func_enable <= 1'h1;
    test_mode_n <= 1'h0;
    for (i = 0; i < 2; i++) begin
      ack_hold_n <= i[0];
      repeat (4) @(posedge sys_clk);
      chk({scan_mode, scan_shift_en}, {1'h1, i[0]});
    end
    run(23'h300020, 1'h1, 1'h0, 2'h0, 2'h3, '0, 3'h0, 0);
    test_mode_n <= 1'h1;
    repeat (4) @(posedge sys_clk);
    chk({scan_mode, scan_shift_en}, '0);
    arst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    chk({primary_data_lanes_oe, ext_data_lanes_oe, half_ack_n_oe}, '0);
    arst_n <= 1'h1;
    repeat (2) @(posedge sys_clk);
    run(23'h30abcd, 1'h1, 1'h1, 2'h1, 2'h3, '0, 3'h2, 1);
    summarize();
  end
endmodule
`default_nettype wire
